// ==== src/acrb_pkg.sv ====
// Purpose: shared constants and types of the converter configuration register banks
// Assumes: 24-bit link frames of 8-bit address and 16-bit data, msb first
// Notes:   register table order below fixes the index of each stored register
package acrb_pkg;

  // link framing
  localparam int        FRAME_BITS     = 24;
  localparam logic [7:0] DAISY_READ_CMD = 8'hFE;

  // bank 0 addresses, reachable under any bank selection
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_CHAIN     = 8'h01;
  localparam logic [7:0] ADDR_BANK      = 8'h03;
  localparam logic [7:0] ADDR_KEY       = 8'h04;
  localparam logic [7:0] ADDR_MIRROR    = 8'h06;

  // serial control word fields and reset values
  localparam int         CTRL_RESET_BIT = 0;
  localparam int         CTRL_RDEN_BIT  = 1;
  localparam int         CTRL_MODE_BIT  = 2;
  localparam logic [15:0] CTRL_RST      = 16'h0000;
  localparam logic [15:0] MIRROR_RST    = 16'h0002;

  // bank selection codes
  localparam logic [7:0] BANK_SEL_B0    = 8'h00;
  localparam logic [7:0] BANK_SEL_B1    = 8'h02;
  localparam logic [7:0] BANK_SEL_B2    = 8'h10;

  // field positions
  localparam int         CHAIN_LO       = 2;
  localparam int         CHAIN_HI       = 6;
  localparam int         BANK_LO        = 0;
  localparam int         BANK_HI        = 7;
  localparam int         FMT_BIT        = 13;
  localparam int         CAL_LO         = 7;
  localparam int         CAL_HI         = 8;
  localparam logic [1:0] CAL_ALL_ON     = 2'h3;
  localparam int         XOR_BIT        = 3;
  localparam int         INC_LO         = 4;
  localparam int         INC_HI         = 7;
  localparam int         PSEL_LO        = 2;
  localparam int         PSEL_HI        = 3;
  localparam int         PEN_BIT        = 1;
  localparam logic [1:0] PSEL_RAMP      = 2'h2;
  localparam logic [1:0] PSEL_ALT       = 2'h3;
  localparam int         TAG_A_LO       = 0;
  localparam int         TAG_B_LO       = 8;
  localparam int         TAG_W          = 8;

  // stored register table
  localparam int NREG = 15;
  localparam int IDX_CHAIN = 0;
  localparam int IDX_BANK  = 1;
  localparam int IDX_KEY   = 2;
  localparam int IDX_FMT   = 3;
  localparam int IDX_SCR   = 4;
  localparam int IDX_GRP   = 5;   // group a control, then pattern0 low, mixed, pattern1 high
  localparam int GRP_STRIDE = 4;  // group b follows group a
  localparam int IDX_TAG   = 13;
  localparam int IDX_UNLK  = 14;
  localparam logic [7:0] REG_ADDR [NREG] = '{8'h01, 8'h03, 8'h04, 8'h0D, 8'h12,
    8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h33};
  localparam logic [15:0] REG_RST [NREG] = '{16'h0000, 16'h0002, 16'h0000, 16'h2002,
    16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};
  localparam logic REG_IN_BANK0 [NREG] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
    1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

  // sample widths
  localparam int RES_W = 18;
  localparam int PAT_W = 24;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } acrb_frame_s;

  typedef struct packed {
    logic              valid;
    logic [PAT_W-1:0]  data;
    logic [TAG_W-1:0]  tag;
  } acrb_sample_s;

endpackage : acrb_pkg

// ==== src/acrb_config_regs.sv ====
// Purpose: configuration register banks and output data controls of the converter
// Assumes: link clock runs only while the frame select is low; host samples sdo on falling edge
// Notes:   frames are whole multiples of 24 bits; the last 24 bits of a frame are decoded
`timescale 1ns/1ns
`default_nettype none

// Operation
// - control bit 2 picks daisy-chain at 0, legacy serial at 1; resets 0.
// - read enable allows reads only in legacy mode; ignored in daisy-chain mode.
// - writing 1 to control bit 0 resets converter and all registers.
// - control word is write-only; a read-only copy reads back, default 2h.
// - chain-length field value N means N+1 devices, 1 to 32.
// - bank select: 0 bank 0, 2 bank 1, 16 bank 2; resets to 2.
// - format bit 13: 0 straight binary, 1 two's complement (reset).
// - gain calibration field: 0 disables all channels, 3 enables all.
// - scramble bit XORs each result bit above the lsb with that result's lsb.
// - ramp advances by increment field plus one per output word.
// - group a select: 0/1 fixed pattern 0, 2 ramp, 3 alternate 0 and 1.
// - group b select offers the same behaviours with group b patterns.
// - pattern enable outputs test pattern; cleared outputs the conversion result.
// - pattern 0 is low register plus low byte of mixed register.
// - pattern 1 is high byte of mixed register plus high register.
// - tag bits of each group are appended to that group's results.
// - bank 0 registers answer whatever the bank selection is.
module acrb_config_regs (
  // system
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // configuration link
  input  wire logic                 linkClk,
  input  wire logic                 csn,
  input  wire logic                 sdi,
  output logic                      sdo,
  // converter results, channels 1-4 and 5-8
  input  wire logic                 convValid,
  input  wire logic [17:0]          convA,
  input  wire logic [17:0]          convB,
  // output data words
  output acrb_pkg::acrb_sample_s    groupAOut,
  output acrb_pkg::acrb_sample_s    groupBOut,
  // converter controls
  output logic                      converterReset,
  output logic                      gainCalEnable,
  output logic [4:0]                chainLength,
  output logic                      legacyMode
);

  // link domain
  logic [23:0]            linkShift_r;
  logic                   firstBit_r;
  logic                   sdo_r;
  // crossings into the register domain
  logic                   csnSync1_r;
  logic                   csnSync2_r;
  logic                   csnSync3_r;
  logic [23:0]            wordSync1_r;
  logic [23:0]            wordSync2_r;
  // register file
  logic [15:0]            regFile_r [acrb_pkg::NREG];
  logic [15:0]            ctrl_r;
  logic [15:0]            mirror_r;
  logic [23:0]            replyWord_r;
  logic                   replyValid_r;
  logic                   converterReset_r;
  logic                   gainCal_r;
  logic [4:0]             chainLen_r;
  logic                   legacy_r;
  // decode
  acrb_pkg::acrb_frame_s  frame;
  logic                   frameEnd;
  logic                   daisyMode;
  logic                   readReq;
  logic                   writeReq;
  logic                   softReset;
  logic [7:0]             readAddr;
  logic [15:0]            readData;
  logic                   bank1Sel;
  logic [acrb_pkg::NREG-1:0] writeHit;
  // output path
  acrb_pkg::acrb_sample_s groupOut_r [2];

  // first edge of a frame takes a pending reply, else passes the chain through;
  // csn clears the frame state since the link clock stops between frames
  always_ff @(posedge linkClk or posedge csn)
  begin
    if (csn)
    begin
      firstBit_r <= 1'b1;
      sdo_r      <= 1'b0;
    end
    else if (firstBit_r && replyValid_r)
    begin
      firstBit_r <= 1'b0;
      sdo_r      <= replyWord_r[23];
    end
    else
    begin
      firstBit_r <= 1'b0;
      sdo_r      <= linkShift_r[23];
    end
  end

  // shift register gives the 24-clock pass-through delay of the chain
  always_ff @(posedge linkClk)
  begin
    if (!csn && firstBit_r && replyValid_r)
    begin
      linkShift_r <= {replyWord_r[22:0], sdi};
    end
    else if (!csn)
    begin
      linkShift_r <= {linkShift_r[22:0], sdi};
    end
  end

  assign sdo = sdo_r;

  // frame select and frame word cross by two flops; word is still once csn is high
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      csnSync1_r <= 1'b1;
      csnSync2_r <= 1'b1;
      csnSync3_r <= 1'b1;
    end
    else
    begin
      csnSync1_r <= csn;
      csnSync2_r <= csnSync1_r;
      csnSync3_r <= csnSync2_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wordSync1_r <= '0;
      wordSync2_r <= '0;
    end
    else
    begin
      wordSync1_r <= linkShift_r;
      wordSync2_r <= wordSync1_r;
    end
  end

  // frame decode at the rising edge of the synchronised select
  assign frameEnd  = csnSync2_r & ~csnSync3_r;
  assign frame     = acrb_pkg::acrb_frame_s'(wordSync2_r);
  assign daisyMode = ~ctrl_r[acrb_pkg::CTRL_MODE_BIT];
  assign bank1Sel  = regFile_r[acrb_pkg::IDX_BANK][acrb_pkg::BANK_HI:acrb_pkg::BANK_LO]
                     == acrb_pkg::BANK_SEL_B1;

  always_comb
  begin
    readReq  = 1'b0;
    readAddr = frame.addr;
    if (daisyMode)
    begin
      // read enable has no meaning here; only the read command reads
      readReq  = frameEnd && (frame.addr == acrb_pkg::DAISY_READ_CMD);
      readAddr = frame.data[7:0];
    end
    else if (ctrl_r[acrb_pkg::CTRL_RDEN_BIT])
    begin
      // control word stays writable so reads can be switched off again
      readReq  = frameEnd && (frame.addr != acrb_pkg::ADDR_CTRL);
    end
  end

  // a daisy read command never doubles as a write
  assign writeReq  = frameEnd && !readReq &&
                     !(daisyMode && frame.addr == acrb_pkg::DAISY_READ_CMD);
  assign softReset = writeReq && (frame.addr == acrb_pkg::ADDR_CTRL) &&
                     frame.data[acrb_pkg::CTRL_RESET_BIT];

  // stored registers, one flop word per table entry
  genvar gi;
  generate
    for (gi = 0; gi < acrb_pkg::NREG; gi++)
    begin : g_reg
      // bank 0 entries ignore the bank selection
      assign writeHit[gi] = writeReq && (frame.addr == acrb_pkg::REG_ADDR[gi]) &&
                            (acrb_pkg::REG_IN_BANK0[gi] || bank1Sel);
      always_ff @(posedge clk)
      begin
        if (!rstn || softReset)
        begin
          regFile_r[gi] <= acrb_pkg::REG_RST[gi];
        end
        else if (writeHit[gi])
        begin
          regFile_r[gi] <= frame.data;
        end
      end
    end
  endgenerate

  // write-only control word and its readable copy
  always_ff @(posedge clk)
  begin
    if (!rstn || softReset)
    begin
      ctrl_r   <= acrb_pkg::CTRL_RST;
      mirror_r <= acrb_pkg::MIRROR_RST;
    end
    else if (writeReq && frame.addr == acrb_pkg::ADDR_CTRL)
    begin
      ctrl_r   <= frame.data;
      mirror_r <= frame.data;
    end
  end

  // converter reset is a one-cycle pulse; the bit itself clears with the registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      converterReset_r <= 1'b0;
    end
    else
    begin
      converterReset_r <= softReset;
    end
  end

  // read mux; unmapped, bank 2 and write-only addresses read as zero
  always_comb
  begin
    readData = 16'h0000;
    if (readAddr == acrb_pkg::ADDR_MIRROR)
    begin
      readData = mirror_r;
    end
    else
    begin
      for (int i = 0; i < acrb_pkg::NREG; i++)
      begin
        if (readAddr == acrb_pkg::REG_ADDR[i] && (acrb_pkg::REG_IN_BANK0[i] || bank1Sel))
        begin
          readData = regFile_r[i];
        end
      end
    end
  end

  // reply waits for the next frame and is dropped at that frame's end
  always_ff @(posedge clk)
  begin
    if (!rstn || softReset)
    begin
      replyWord_r  <= '0;
      replyValid_r <= 1'b0;
    end
    else if (readReq)
    begin
      replyWord_r  <= {readAddr, readData};
      replyValid_r <= 1'b1;
    end
    else if (frameEnd)
    begin
      replyValid_r <= 1'b0;
    end
  end

  // static controls toward the converter
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      gainCal_r  <= 1'b0;
      chainLen_r <= '0;
      legacy_r   <= 1'b0;
    end
    else
    begin
      gainCal_r  <= regFile_r[acrb_pkg::IDX_FMT][acrb_pkg::CAL_HI:acrb_pkg::CAL_LO]
                    == acrb_pkg::CAL_ALL_ON;
      chainLen_r <= regFile_r[acrb_pkg::IDX_CHAIN][acrb_pkg::CHAIN_HI:acrb_pkg::CHAIN_LO];
      legacy_r   <= ctrl_r[acrb_pkg::CTRL_MODE_BIT];
    end
  end

  // output path, one copy per four-channel group
  genvar gg;
  generate
    for (gg = 0; gg < 2; gg++)
    begin : g_grp
      localparam int BASE = acrb_pkg::IDX_GRP + gg * acrb_pkg::GRP_STRIDE;
      localparam int TLO  = (gg == 0) ? acrb_pkg::TAG_A_LO : acrb_pkg::TAG_B_LO;
      logic [15:0]             pctl;
      logic [1:0]              psel;
      logic                    pen;
      logic [23:0]             pattern0;
      logic [23:0]             pattern1;
      logic [23:0]             rampCnt_r;
      logic                    altSel_r;
      logic [17:0]             raw;
      logic [17:0]             fmtd;
      logic [17:0]             scr;
      logic [23:0]             rampStep;

      assign pctl     = regFile_r[BASE];
      assign psel     = pctl[acrb_pkg::PSEL_HI:acrb_pkg::PSEL_LO];
      assign pen      = pctl[acrb_pkg::PEN_BIT];
      assign pattern0 = {regFile_r[BASE+2][7:0], regFile_r[BASE+1]};
      assign pattern1 = {regFile_r[BASE+3], regFile_r[BASE+2][15:8]};
      assign rampStep = {20'h00000, pctl[acrb_pkg::INC_HI:acrb_pkg::INC_LO]} + 24'h000001;
      assign raw      = (gg == 0) ? convA : convB;

      // converter delivers two's complement; straight binary flips the sign bit
      assign fmtd = regFile_r[acrb_pkg::IDX_FMT][acrb_pkg::FMT_BIT] ? raw :
                    {~raw[17], raw[16:0]};
      // lsb is kept so the receiver can undo the scramble
      assign scr  = regFile_r[acrb_pkg::IDX_SCR][acrb_pkg::XOR_BIT] ?
                    {fmtd[17:1] ^ {17{fmtd[0]}}, fmtd[0]} : fmtd;

      // ramp runs only in ramp mode and restarts from zero otherwise
      always_ff @(posedge clk)
      begin
        if (!rstn || !(pen && psel == acrb_pkg::PSEL_RAMP))
        begin
          rampCnt_r <= '0;
        end
        else if (convValid)
        begin
          rampCnt_r <= rampCnt_r + rampStep;
        end
      end

      // alternate selector flips once per output sample
      always_ff @(posedge clk)
      begin
        if (!rstn || !(pen && psel == acrb_pkg::PSEL_ALT))
        begin
          altSel_r <= 1'b0;
        end
        else if (convValid)
        begin
          altSel_r <= ~altSel_r;
        end
      end

      // output word; tag bits ride only on conversion results
      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          groupOut_r[gg] <= '0;
        end
        else
        begin
          groupOut_r[gg].valid <= convValid;
          if (pen)
          begin
            groupOut_r[gg].tag <= '0;
            case (psel)
              acrb_pkg::PSEL_RAMP: groupOut_r[gg].data <= rampCnt_r;
              acrb_pkg::PSEL_ALT:  groupOut_r[gg].data <= altSel_r ? pattern1 : pattern0;
              default:             groupOut_r[gg].data <= pattern0;
            endcase
          end
          else
          begin
            // result sits in the low bits, extended to match its format
            groupOut_r[gg].data <= {{6{scr[17] & regFile_r[acrb_pkg::IDX_FMT][acrb_pkg::FMT_BIT]}},
                                    scr};
            groupOut_r[gg].tag  <= regFile_r[acrb_pkg::IDX_TAG][TLO +: acrb_pkg::TAG_W];
          end
        end
      end
    end
  endgenerate

  // outputs straight from flops
  assign groupAOut      = groupOut_r[0];
  assign groupBOut      = groupOut_r[1];
  assign converterReset = converterReset_r;
  assign gainCalEnable  = gainCal_r;
  assign chainLength    = chainLen_r;
  assign legacyMode     = legacy_r;

endmodule : acrb_config_regs

`default_nettype wire

// ==== tb/acrb_config_regs_chk.sv ====
// Purpose: port-level assertions for the configuration register banks
// Assumes: link frames decode only after the frame select has gone high
// Notes:   bound to every instance of the register bank
`timescale 1ns/1ns
`default_nettype none
module acrb_config_regs_chk (
  // system
  input wire logic                  clk,
  input wire logic                  rstn,
  // link
  input wire logic                  csn,
  input wire logic                  sdo,
  // converter path
  input wire logic                  convValid,
  input wire acrb_pkg::acrb_sample_s groupAOut,
  input wire acrb_pkg::acrb_sample_s groupBOut,
  // controls
  input wire logic                  converterReset,
  input wire logic                  gainCalEnable,
  input wire logic                  legacyMode,
  input wire logic [4:0]            chainLength
);
  // one clock domain, so one default clocking and disable
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_valid_a_after: assert property (convValid |=> groupAOut.valid)
    else $error("group a word missing after result");
  a_valid_b_after: assert property (convValid |=> groupBOut.valid)
    else $error("group b word missing after result");
  a_valid_has_cause: assert property ((groupAOut.valid || groupBOut.valid) |-> $past(convValid))
    else $error("output word without a result");
  a_pulse_single: assert property (converterReset |=> !converterReset)
    else $error("converter reset longer than one cycle");
  a_pulse_after_frame: assert property (converterReset |-> $past(csn, 2) && $past(csn, 3))
    else $error("converter reset inside a frame");
  a_soft_clears: assert property (converterReset |=> chainLength == 5'h00 && !legacyMode)
    else $error("controls not restored by soft reset");
  a_chain_after_frame: assert property ($changed(chainLength) |-> $past(csn) && $past(csn, 2))
    else $error("chain length changed inside a frame");
  a_cal_after_frame: assert property ($changed(gainCalEnable) |-> $past(csn) && $past(csn, 2))
    else $error("calibration changed inside a frame");
  a_mode_after_frame: assert property ($changed(legacyMode) |-> $past(csn) && $past(csn, 2))
    else $error("interface mode changed inside a frame");
  a_release_defaults: assert property ($rose(rstn) |-> chainLength == 5'h00 && !legacyMode && !gainCalEnable)
    else $error("controls not at defaults after reset");
  a_sdo_idle: assert property (csn && $past(csn) |-> !sdo)
    else $error("serial out active between frames");
endmodule : acrb_config_regs_chk

bind acrb_config_regs acrb_config_regs_chk chk (.clk(clk), .rstn(rstn), .csn(csn), .sdo(sdo),
  .convValid(convValid), .groupAOut(groupAOut), .groupBOut(groupBOut),
  .converterReset(converterReset), .gainCalEnable(gainCalEnable), .legacyMode(legacyMode),
  .chainLength(chainLength));
`default_nettype wire

// ==== tb/acrb_spi_host.sv ====
// Purpose: behavioural host of the configuration link
// Assumes: 160 ns link clock that runs only inside frames
// Notes:   shifts on falling edge, samples serial out on falling edge
`timescale 1ns/1ns
`default_nettype none
module acrb_spi_host (
  // link
  output logic      linkClk,
  output logic      csn,
  output logic      sdi,
  input wire logic  sdo
);
  // idle link: clock still, frame select high
  initial
  begin
    linkClk = 1'b0;
    csn = 1'b1;
    sdi = 1'b0;
  end

  // one 24-bit frame, msb first, then a gap long enough for decode
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    // small lead keeps select and link edges off the system clock's rising edge
    #3 csn = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdi = tx[i];
      #80 linkClk = 1'b1;
      #80 linkClk = 1'b0;
      rx[i] = sdo;
    end
    csn = 1'b1;
    sdi = ~sdi; // released line must not keep its last value
    #197;
  endtask : xfer

  // start-up keys, each returned to its idle value
  task automatic startup;
    logic [23:0] r;
    xfer({8'h04, 16'h000B}, r);
    xfer({8'h04, 16'h0000}, r);
    xfer({8'h33, 16'h0030}, r);
    xfer({8'h33, 16'h0000}, r);
  endtask : startup
endmodule : acrb_spi_host
`default_nettype wire

// ==== tb/acrb_config_regs_tb_top.sv ====
// Purpose: self-checking bench of the configuration register banks
// Assumes: host model drives the link; all writes keep reserved bits at reset value
// Notes:   expected words are worked out from the register layout
`timescale 1ns/1ns
`default_nettype none
module acrb_config_regs_tb_top;
  logic                   clk, rstn, convValid, converterReset, gainCalEnable, legacyMode;
  logic                   linkClk, csn, sdi, sdo;
  logic [17:0]            convA, convB;
  logic [4:0]             chainLength;
  logic [23:0]            rx;
  acrb_pkg::acrb_sample_s groupAOut, groupBOut, sa, sb;
  int                     n_fail, check_count, cycles, nPulse;

  acrb_config_regs dut (.clk(clk), .rstn(rstn), .linkClk(linkClk), .csn(csn), .sdi(sdi),
    .sdo(sdo), .convValid(convValid), .convA(convA), .convB(convB), .groupAOut(groupAOut),
    .groupBOut(groupBOut), .converterReset(converterReset), .gainCalEnable(gainCalEnable),
    .chainLength(chainLength), .legacyMode(legacyMode));
  acrb_spi_host host (.linkClk(linkClk), .csn(csn), .sdi(sdi), .sdo(sdo));

  // 100 MHz system clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // hang guard and soft reset pulse count
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (converterReset === 1'b1)
      nPulse <= nPulse + 1;
    if (cycles == 60000)
    begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.xfer({a, d}, rx);
  endtask : wr

  // chain-mode read: request frame, then an all-ones frame carries the reply
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    host.xfer({8'hFE, 8'h00, a}, rx);
    host.xfer(24'hFFFFFF, rx);
    chk("read", 33'({a, e}), 33'(rx));
  endtask : rd

  task automatic conv(input logic [17:0] a, input logic [17:0] b);
    @(posedge clk);
    convValid <= 1'b1;
    convA <= a;
    convB <= b;
    @(posedge clk);
    convValid <= 1'b0;
    #1;
    sa = groupAOut;
    sb = groupBOut;
  endtask : conv

  task automatic t_defaults;
    logic [7:0]  ad [6] = '{8'h03, 8'h0D, 8'h12, 8'h06, 8'h00, 8'h33};
    logic [15:0] dv [6] = '{16'h0002, 16'h2002, 16'h0002, 16'h0002, 16'h0000, 16'h0000};
    for (int i = 0; i < 6; i++)
      rd(ad[i], dv[i]);
    chk("legacy", 33'h0, 33'(legacyMode));
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_chain;
    wr(8'h01, 16'h007C);
    chk("chain", 33'h1F, 33'(chainLength));
    rd(8'h01, 16'h007C);
    wr(8'h01, 16'h0000);
    chk("chain", 33'h00, 33'(chainLength));
    $display("test chain done");
  endtask : t_chain

  task automatic t_bank;
    wr(8'h03, 16'h0010);
    wr(8'h0D, 16'h0002);
    rd(8'h0D, 16'h0000);
    wr(8'h01, 16'h0008);
    rd(8'h01, 16'h0008);
    wr(8'h03, 16'h0000);
    rd(8'h03, 16'h0000);
    wr(8'h03, 16'h0002);
    rd(8'h0D, 16'h2002);
    $display("test bank done");
  endtask : t_bank

  task automatic t_format;
    wr(8'h1C, 16'hA55A);
    conv(18'h3FFFF, 18'h00005);
    chk("wordA", {1'b1, 24'hFFFFFF, 8'h5A}, sa);
    chk("wordB", {1'b1, 24'h000005, 8'hA5}, sb);
    wr(8'h0D, 16'h0182);
    chk("cal", 33'h1, 33'(gainCalEnable));
    conv(18'h3FFFF, 18'h00005);
    chk("wordA", {1'b1, 24'h01FFFF, 8'h5A}, sa);
    chk("wordB", {1'b1, 24'h020005, 8'hA5}, sb);
    wr(8'h12, 16'h000A);
    conv(18'h00003, 18'h00004);
    chk("xorA", {1'b1, 24'h01FFFD, 8'h5A}, sa);
    chk("xorB", {1'b1, 24'h020004, 8'hA5}, sb);
    wr(8'h12, 16'h0002);
    wr(8'h0D, 16'h2002);
    chk("cal", 33'h0, 33'(gainCalEnable));
    $display("test format done");
  endtask : t_format

  // one sample; the other group must still carry its conversion result
  task automatic look(input logic b, input logic [32:0] eo);
    conv(18'h00007, 18'h00007);
    chk("own", eo, b ? sb : sa);
    chk("other", {1'b1, 24'h000007, b ? 8'h5A : 8'hA5}, b ? sa : sb);
  endtask : look

  task automatic t_group(input logic [7:0] cb);
    logic        b;
    logic [32:0] p0, p1;
    b = (cb == 8'h18);
    p0 = {1'b1, 24'h123456, 8'h00};
    p1 = {1'b1, 24'h789ABC, 8'h00};
    wr(cb + 8'h01, 16'h3456);
    wr(cb + 8'h02, 16'hBC12);
    wr(cb + 8'h03, 16'h789A);
    for (int m = 0; m < 2; m++)
    begin
      wr(cb, 16'(m * 4 + 2));
      look(b, p0);
    end
    wr(cb, 16'h000E);
    for (int i = 0; i < 3; i++)
      look(b, (i % 2) ? p1 : p0);
    wr(cb, 16'h003A);
    for (int i = 0; i < 3; i++)
      look(b, {1'b1, 24'(i * 4), 8'h00});
    wr(cb, 16'h0000);
    look(b, {1'b1, 24'h000007, b ? 8'hA5 : 8'h5A});
    $display("test group done");
  endtask : t_group

  task automatic t_legacy;
    wr(8'h00, 16'h0002);
    wr(8'h01, 16'h0010);
    chk("chain", 33'h04, 33'(chainLength));
    wr(8'h00, 16'h0006);
    chk("legacy", 33'h1, 33'(legacyMode));
    host.xfer({8'h06, 16'h0000}, rx);
    host.xfer({8'h01, 16'hFFFF}, rx);
    chk("mirror", 33'h060006, 33'(rx));
    host.xfer({8'h00, 16'h0004}, rx);
    chk("legread", 33'h010010, 33'(rx));
    wr(8'h00, 16'h0001);
    chk("pulses", 33'h1, 33'(nPulse));
    chk("legacy", 33'h0, 33'(legacyMode));
    rd(8'h1C, 16'h0000);
    $display("test legacy done");
  endtask : t_legacy

  // reset, then every test in turn
  initial
  begin
    rstn = 1'b0;
    convValid = 1'b0;
    convA = '0;
    convB = '0;
    n_fail = 0;
    check_count = 0;
    cycles = 0;
    nPulse = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    host.startup();
    t_defaults();
    t_chain();
    t_bank();
    t_format();
    t_group(8'h13);
    t_group(8'h18);
    t_legacy();
    complete_run();
  end
endmodule : acrb_config_regs_tb_top
`default_nettype wire
